/* hdl/dram_address_refresh_controller.sv */
// multi-mode dram address multiplexer, strobe sequencer and refresh control
// assumes host strobes are async pins, synchronised here; strobe outputs active low, enables active high
// Function
// RULE1: address strobe high passes inputs to latches
// RULE2: address strobe falling edge holds latched inputs
// RULE3: decode bank bits, assert one row strobe
// RULE4: after row strobe, switch to column, then column strobe
// RULE5: write enable copies input after 20 ns (code: one 50 ns core_clk cycle after the two-stage synchroniser)
// RULE6: mode code 101 is automatic access
// RULE7: clearing refresh bit gives forced refresh mode
// RULE8: chip select high floats address outputs
// RULE9: chip select high floats strobe outputs too
// RULE10: mode 5 deselect with period clock high hides refresh
// RULE11: only one shared controller performs refresh
// RULE12: external low on refresh pin clears counter
// RULE13: refresh pin low at selected terminal count
// RULE14: auto refresh mode makes pin a request
// RULE15: address outputs from exactly one source
// RULE16: nine-bit variant shares clock inputs
// RULE17: nine-bit bus, eight-bit variant without shared clocks
// RULE18: refresh drives counter, all row strobes, no column
// RULE19: counter increments when row strobe input rises
// RULE20: counter runs full range, decode only
// RULE21: external access: inputs drive strobes and source
// RULE22: access delays are clock cycle counts
// RULE23: undefined modes idle strobes, row address out
`timescale 1ns/10ps
module dram_address_refresh_controller
   import dram_ctl_pkg::*;
#(
   parameter int ADDR_WIDTH = 9,
   parameter int ROW_HOLD_CYCLES = ROW_HOLD_CYC,
   parameter int COL_SETUP_CYCLES = COL_SETUP_CYC,
   parameter int WE_DELAY_CYCLES = WE_DELAY_CYC
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [ADDR_WIDTH-1:0] row_addr,
   input wire logic [ADDR_WIDTH-1:0] col_addr,
   input wire logic bank_select_lo,
   input wire logic bank_select_hi,
   input wire logic address_latch_strobe,
   input wire logic row_strobe_input_n,
   input wire logic column_strobe_input_n,
   input wire logic row_col_select,
   input wire logic write_enable_input_n,
   input wire logic chip_select_n,
   input wire logic mode_sel_bit0,
   input wire logic mode_sel_bit1,
   input wire logic mode_sel_refresh_bit,
   input wire logic [1:0] eoc_sel,
   input wire logic refresh_status_pin_in,
   output logic refresh_status_pin_out,
   output logic refresh_status_pin_oe,
   output logic [ADDR_WIDTH-1:0] mux_addr,
   output logic mux_addr_oe,
   output logic [3:0] row_strobe_n,
   output logic column_strobe_n,
   output logic write_enable_n,
   output logic strobe_oe
);
   localparam int NSYNC = 12 + 2 * ADDR_WIDTH;
   localparam bit SHARED_CLOCKS = (ADDR_WIDTH >= 9); // [RULE16] [RULE17]

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [NSYNC-1:0] sync_in;
   logic [NSYNC-1:0] sync_out;
   logic als_s, ras_in_s, cas_in_s, rc_s, we_in_s, cs_n_s, rf_pin_s;
   logic [2:0] mode_s;
   logic [ADDR_WIDTH-1:0] row_addr_s, col_addr_s;
   logic [1:0] bank_s;

   assign sync_in = {row_addr, col_addr, bank_select_hi, bank_select_lo,
                     address_latch_strobe, row_strobe_input_n, column_strobe_input_n,
                     row_col_select, write_enable_input_n, chip_select_n,
                     mode_sel_refresh_bit, mode_sel_bit1, mode_sel_bit0,
                     refresh_status_pin_in};

   sync_two_ff #(.WIDTH(NSYNC)) u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(sync_in),
      .sync_out(sync_out)
   );

   assign {als_s, ras_in_s, cas_in_s, rc_s, we_in_s, cs_n_s} = sync_out[9:4];
   assign mode_s = sync_out[3:1];
   assign rf_pin_s = sync_out[0];
   assign {row_addr_s, col_addr_s, bank_s} = sync_out[NSYNC-1:10];

   // period clock shares the row/column pin in the nine-bit variant
   logic period_clk;
   assign period_clk = SHARED_CLOCKS ? rc_s : 1'b0; // [RULE16]

   ////////////////////////////////////////////////////////////////////////////
   // input latches: transparent while strobe high, hold after it falls
   logic [ADDR_WIDTH-1:0] row_lat_reg, row_lat_next, col_lat_reg, col_lat_next;
   logic [1:0] bank_reg, bank_next;

   always_comb begin
      row_lat_next = row_lat_reg;
      col_lat_next = col_lat_reg;
      bank_next = bank_reg;
      if (als_s) begin
         row_lat_next = row_addr_s; // [RULE1]
         col_lat_next = col_addr_s;
         bank_next = bank_s;
      end // strobe low: hold [RULE2]
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         row_lat_reg <= '0;
         col_lat_reg <= '0;
         bank_reg <= '0;
      end else begin
         row_lat_reg <= row_lat_next;
         col_lat_reg <= col_lat_next;
         bank_reg <= bank_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write enable delay line
   logic [WE_DELAY_CYCLES-1:0] we_pipe_reg, we_pipe_next;
   logic [WE_DELAY_CYCLES:0] we_shift;
   always_comb begin
      we_shift = {we_in_s, we_pipe_reg};
      we_pipe_next = we_shift[WE_DELAY_CYCLES:1];
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         we_pipe_reg <= '1;
      end else begin
         we_pipe_reg <= we_pipe_next;
      end
   end
   assign write_enable_n = we_pipe_reg[0]; // [RULE5]

   ////////////////////////////////////////////////////////////////////////////
   // automatic access sequencer
   typedef enum logic [1:0] {ACC_IDLE, ACC_ROW, ACC_COL, ACC_CAS} acc_state_t;
   acc_state_t acc_reg, acc_next;
   logic [7:0] dly_reg, dly_next;
   logic auto_mode, ext_mode, forced_ref, auto_ref, hidden_ref, ras_prev_reg;

   assign auto_mode = (mode_s == MODE_AUTO_ACCESS); // [RULE6]
   assign forced_ref = (mode_s == MODE_EXT_REFRESH) || (mode_s == MODE_AUTO_REFRESH); // [RULE7]
   assign auto_ref = (mode_s == MODE_AUTO_REFRESH) && SHARED_CLOCKS;
   assign ext_mode = (mode_s == MODE_EXT_ACCESS);
   // deselected in mode 5 with period clock high: hidden refresh
   assign hidden_ref = auto_mode && cs_n_s && period_clk && SHARED_CLOCKS; // [RULE10]

   always_comb begin
      acc_next = acc_reg;
      dly_next = dly_reg;
      if (!auto_mode || cs_n_s || ras_in_s) begin
         acc_next = ACC_IDLE;
         dly_next = '0;
      end else begin
         case (acc_reg)
            ACC_IDLE: begin
               acc_next = ACC_ROW;
               dly_next = 8'(ROW_HOLD_CYCLES); // [RULE22]
            end
            ACC_ROW: begin
               if (dly_reg <= 8'h01) begin
                  acc_next = ACC_COL; // [RULE4]
                  dly_next = 8'(COL_SETUP_CYCLES);
               end else begin
                  dly_next = dly_reg - 8'h01;
               end
            end
            ACC_COL: begin
               if (dly_reg <= 8'h01) begin
                  acc_next = ACC_CAS; // [RULE4]
               end else begin
                  dly_next = dly_reg - 8'h01;
               end
            end
            default: acc_next = ACC_CAS;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         acc_reg <= ACC_IDLE;
         dly_reg <= '0;
         ras_prev_reg <= 1'b1;
      end else begin
         acc_reg <= acc_next;
         dly_reg <= dly_next;
         ras_prev_reg <= ras_in_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // refresh counter
   logic [ADDR_WIDTH-1:0] ref_count;
   logic end_of_count, refreshing, ref_inc, pin_clear;

   assign refreshing = forced_ref || hidden_ref;
   assign ref_inc = refreshing && ras_in_s && !ras_prev_reg; // [RULE19]
   // our own pull-down still shows on the synced pin for two cycles after release
   logic [1:0] oe_hist_reg, oe_hist_next;
   assign oe_hist_next = {oe_hist_reg[0], refresh_status_pin_oe};
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         oe_hist_reg <= '0;
      end else begin
         oe_hist_reg <= oe_hist_next;
      end
   end
   // external low only counts when we have not driven it lately
   assign pin_clear = !rf_pin_s && !refresh_status_pin_oe && (oe_hist_reg == 2'h0); // [RULE12]

   refresh_counter #(.WIDTH(ADDR_WIDTH)) u_refresh_counter (
      .core_clk(core_clk),
      .reset(reset),
      .inc_pulse(ref_inc),
      .clear(pin_clear),
      .eoc_sel(eoc_sel),
      .count(ref_count),
      .end_of_count(end_of_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // output registers: address source, strobes, enables
   logic [ADDR_WIDTH-1:0] addr_reg, addr_next;
   logic [3:0] ras_o_reg, ras_o_next, bank_dec;
   logic cas_o_reg, cas_o_next, aoe_reg, aoe_next, soe_reg, soe_next;
   logic req_reg, req_next;
   addr_src_t src;

   always_comb begin
      bank_dec = 4'h0;
      bank_dec[bank_reg] = 1'b1; // [RULE3]
      src = SRC_ROW; // [RULE23]
      ras_o_next = 4'hF;
      cas_o_next = 1'b1;
      if (refreshing) begin
         src = SRC_REFRESH; // [RULE18]
         ras_o_next = ras_in_s ? 4'hF : 4'h0;
      end else if (auto_mode && !cs_n_s) begin
         src = (acc_reg == ACC_COL || acc_reg == ACC_CAS) ? SRC_COL : SRC_ROW;
         ras_o_next = ras_in_s ? 4'hF : ~bank_dec; // [RULE3]
         cas_o_next = (acc_reg != ACC_CAS); // [RULE4]
      end else if (ext_mode && !cs_n_s) begin
         src = rc_s ? SRC_ROW : SRC_COL; // [RULE21]
         ras_o_next = ras_in_s ? 4'hF : ~bank_dec;
         cas_o_next = cas_in_s;
      end
      case (src)
         SRC_COL: addr_next = col_lat_reg; // [RULE15]
         SRC_REFRESH: addr_next = ref_count;
         default: addr_next = row_lat_reg;
      endcase
      aoe_next = !cs_n_s || hidden_ref; // [RULE8]
      soe_next = !cs_n_s || hidden_ref; // [RULE9]
      req_next = auto_ref ? !period_clk : 1'b0; // [RULE14]
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         addr_reg <= '0;
         ras_o_reg <= 4'hF;
         cas_o_reg <= 1'b1;
         aoe_reg <= 1'b0;
         soe_reg <= 1'b0;
         req_reg <= 1'b0;
      end else begin
         addr_reg <= addr_next;
         ras_o_reg <= ras_o_next;
         cas_o_reg <= cas_o_next;
         aoe_reg <= aoe_next;
         soe_reg <= soe_next;
         req_reg <= req_next;
      end
   end

   assign mux_addr = addr_reg;
   assign mux_addr_oe = aoe_reg;
   assign row_strobe_n = ras_o_reg;
   assign column_strobe_n = cas_o_reg;
   assign strobe_oe = soe_reg;
   // open-drain: drive low on request or end of count
   assign refresh_status_pin_out = 1'b0;
   assign refresh_status_pin_oe = auto_ref ? req_reg : end_of_count; // [RULE13] [RULE14]

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_acc_start;
      auto_mode && !cs_n_s && !ras_in_s && acc_reg == ACC_IDLE;
   endsequence
   sequence s_steady_access;
      auto_mode && !cs_n_s && !ras_in_s;
   endsequence

   a_one_bank: assert property (@(posedge core_clk) disable iff (reset)
      (!refreshing && !ras_o_next[bank_reg] |-> $onehot(~ras_o_next)))
      else $error("more than one bank strobed"); // [RULE3]
   a_cas_after_col: assert property (@(posedge core_clk) disable iff (reset)
      $fell(cas_o_reg) && !ext_mode |-> $past(acc_reg) == ACC_CAS)
      else $error("column strobe before column phase"); // [RULE4]
   a_auto_seq: assert property (@(posedge core_clk) disable iff (reset)
      s_acc_start ##1 s_steady_access [*2] |-> acc_reg != ACC_IDLE)
      else $error("automatic access did not sequence"); // [RULE6]
   a_deselect_float: assert property (@(posedge core_clk) disable iff (reset)
      cs_n_s && !hidden_ref |=> !mux_addr_oe && !strobe_oe)
      else $error("outputs driven while deselected"); // [RULE8]
   a_hidden_ref: assert property (@(posedge core_clk) disable iff (reset)
      hidden_ref |=> strobe_oe && mux_addr == $past(ref_count))
      else $error("hidden refresh not performed"); // [RULE10]
   a_refresh_cas: assert property (@(posedge core_clk) disable iff (reset)
      refreshing && !ras_in_s |=> column_strobe_n && row_strobe_n == 4'h0)
      else $error("refresh strobes wrong"); // [RULE18]
   a_we_follow: assert property (@(posedge core_clk) disable iff (reset)
      ##WE_DELAY_CYCLES write_enable_n == $past(we_in_s, WE_DELAY_CYCLES))
      else $error("write enable not delayed copy"); // [RULE5]
   a_undef_idle: assert property (@(posedge core_clk) disable iff (reset)
      !refreshing && !auto_mode && !ext_mode |=> row_strobe_n == 4'hF && column_strobe_n)
      else $error("strobes active in undefined mode"); // [RULE23]
   a_ext_cas: assert property (@(posedge core_clk) disable iff (reset)
      ext_mode && !cs_n_s && !refreshing |=> column_strobe_n == $past(cas_in_s))
      else $error("external column strobe not followed"); // [RULE21]
endmodule // dram_address_refresh_controller

/* hdl/refresh_counter.sv */
// refresh row counter with clear and end-of-count decode
// assumes inc_pulse and clear are one-cycle or level signals on core_clk
`timescale 1ns/10ps
module refresh_counter
   import dram_ctl_pkg::*;
#(
   parameter int WIDTH = 9
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic inc_pulse,
   input wire logic clear,
   input wire logic [1:0] eoc_sel,
   output logic [WIDTH-1:0] count,
   output logic end_of_count
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic [WIDTH-1:0] term;

   ////////////////////////////////////////////////////////////////////////////
   // count, clear wins; wraps at full range regardless of terminal setting
   always_comb begin
      count_next = count_reg;
      if (clear) begin
         count_next = '0; // [RULE12]
      end else if (inc_pulse) begin
         count_next = count_reg + 1'b1; // [RULE19] [RULE20]
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   // terminal count decode only, never resets the counter
   always_comb begin
      if (eoc_sel == EOC_SEL_127) begin
         term = WIDTH'(EOC_127);
      end else if (eoc_sel == EOC_SEL_255 || WIDTH < 9) begin
         term = WIDTH'(EOC_255);
      end else begin
         term = WIDTH'(EOC_511);
      end
   end

   assign count = count_reg;
   assign end_of_count = (count_reg == term); // [RULE13]

   a_count_wraps: assert property (@(posedge core_clk) disable iff (reset)
      (!clear && inc_pulse && count_reg == term && term != '1) |=> count_reg != '0)
      else $error("counter reset at end of count"); // [RULE20]
endmodule // refresh_counter

/* hdl/sync_two_ff.sv */
// two flip-flop synchroniser for asynchronous pin inputs
// assumes the destination runs on core_clk
`timescale 1ns/10ps
module sync_two_ff #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   ////////////////////////////////////////////////////////////////////////////
   // next values: first stage only feeds the second
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // register both stages
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         meta_reg <= '1;
         sync_reg <= '1;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule // sync_two_ff

/* inc/dram_ctl_pkg.sv */
// constants shared by the dram address and refresh controller
// assumes a 20 MHz core clock; all strobes except the address latch strobe are active low at the pins
package dram_ctl_pkg;
   localparam int CLK_PERIOD_NS = 50;
   // write enable follow delay, rounded up to whole cycles
   localparam int WE_DELAY_NS = 20;
   localparam int WE_DELAY_CYC = (WE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // on-chip row hold and column setup delays
   localparam int ROW_HOLD_NS = 30;
   localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COL_SETUP_NS = 12;
   localparam int COL_SETUP_CYC = (COL_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // mode codes {refresh_bit, bit1, bit0}
   localparam logic [2:0] MODE_EXT_REFRESH = 3'h0;
   localparam logic [2:0] MODE_AUTO_REFRESH = 3'h1;
   localparam logic [2:0] MODE_EXT_ACCESS = 3'h4;
   localparam logic [2:0] MODE_AUTO_ACCESS = 3'h5;
   // end-of-count selection
   localparam logic [1:0] EOC_SEL_127 = 2'h0;
   localparam logic [1:0] EOC_SEL_255 = 2'h1;
   localparam int EOC_127 = 127;
   localparam int EOC_255 = 255;
   localparam int EOC_511 = 511;
   // address source of the multiplexed outputs
   typedef enum logic [1:0] {SRC_ROW, SRC_COL, SRC_REFRESH} addr_src_t;
endpackage

/* testbench/dram_bus_model.sv */
// far side model: memory address bus with pull-up, open-drain refresh pin
// assumes one controller drives the bus; ext_pull acts as the external gate
`timescale 1ns/10ps
module dram_bus_model (
   input wire logic [8:0] mux_addr,
   input wire logic mux_addr_oe,
   input wire logic pin_out,
   input wire logic pin_oe,
   input wire logic ext_pull,
   output logic [8:0] bus_addr,
   output logic pin_level
);
   ////////////////////////////////////////////////////////////////////////
   // released address lines float up through the pull-up resistors
   assign bus_addr = mux_addr_oe ? mux_addr : 9'h1ff;
   // wired-and of controller drive and external open-collector gate
   assign pin_level = (pin_oe && !pin_out) || ext_pull ? 1'b0 : 1'b1;
endmodule // dram_bus_model

/* testbench/tb.sv */
// bench for the dram address and refresh controller
// assumes default parameters; inputs change on the falling edge
`timescale 1ns/10ps
module tb;
   import dram_ctl_pkg::*;
   logic core_clk = 0, reset = 1, strobe = 0, ras_n = 1, cas_n = 1, rcs = 1;
   logic win_n = 1, cs_n = 0, m0 = 0, m1 = 0, m2 = 1, ext_pull = 0;
   logic bs_lo = 0, bs_hi = 0, pin_out, pin_oe, pin_level, mux_oe, col_n, we_n, s_oe;
   logic [1:0] eoc_sel = 2'h0;
   logic [8:0] row_addr = 9'h000, col_addr = 9'h000, mux_addr, bus_addr;
   logic [3:0] row_n;
   int n_fail = 0, cmp_count = 0, cyc = 0;
   ////////////////////////////////////////////////////////////////////////
   // clock and timeout
   initial forever #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // design and far side
   dram_address_refresh_controller i_dram_address_refresh_controller (
      .core_clk(core_clk), .reset(reset), .row_addr(row_addr), .col_addr(col_addr),
      .bank_select_lo(bs_lo), .bank_select_hi(bs_hi), .address_latch_strobe(strobe),
      .row_strobe_input_n(ras_n), .column_strobe_input_n(cas_n), .row_col_select(rcs),
      .write_enable_input_n(win_n), .chip_select_n(cs_n), .mode_sel_bit0(m0),
      .mode_sel_bit1(m1), .mode_sel_refresh_bit(m2), .eoc_sel(eoc_sel),
      .refresh_status_pin_in(pin_level), .refresh_status_pin_out(pin_out),
      .refresh_status_pin_oe(pin_oe), .mux_addr(mux_addr), .mux_addr_oe(mux_oe),
      .row_strobe_n(row_n), .column_strobe_n(col_n), .write_enable_n(we_n),
      .strobe_oe(s_oe));
   dram_bus_model i_dram_bus_model (.mux_addr(mux_addr), .mux_addr_oe(mux_oe),
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_pull(ext_pull), .bus_addr(bus_addr),
      .pin_level(pin_level));
   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic set_mode(input logic [2:0] m);
      {m2, m1, m0} = m;
      tick(4);
   endtask
   // one refresh cycle; counter expected on the bus while row strobe is low
   task automatic refresh(input logic [8:0] exp);
      ras_n = 0;
      tick(4);
      chk(mux_addr, exp);
      chk(row_n, 4'h0);
      chk(col_n, 1'b1);
      ras_n = 1;
      tick(4);
   endtask
   // latch addresses, then disturb the inputs behind the closed latch
   task automatic latch(input logic [8:0] r, input logic [8:0] c, input logic [1:0] b);
      strobe = 1;
      row_addr = r;
      col_addr = c;
      {bs_hi, bs_lo} = b;
      tick(4);
      strobe = 0;
      tick(4);
      row_addr = ~r;
      col_addr = ~c;
      {bs_hi, bs_lo} = ~b;
   endtask
   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      tick(10);
      reset = 0;
      tick(4);
      chk(we_n, 1'b1);
      win_n = 0;
      tick(4);
      chk(we_n, 1'b0);
      win_n = 1;
      set_mode(MODE_EXT_REFRESH);
      for (int i = 0; i < 3; i++) refresh(i[8:0]);
      ext_pull = 1;
      tick(4);
      ext_pull = 0;
      tick(4);
      for (int i = 0; i < 127; i++) refresh(i[8:0]);
      chk(pin_oe, 1'b1);
      chk(pin_level, 1'b0);
      for (int i = 127; i < 255; i++) refresh(i[8:0]);
      chk(pin_oe, 1'b0);
      eoc_sel = 2'h1;
      tick(2);
      chk(pin_oe, 1'b1);
      eoc_sel = 2'h2;
      for (int i = 255; i < 511; i++) refresh(i[8:0]);
      chk(pin_oe, 1'b1);
      refresh(9'h1ff);
      refresh(9'h000);
      // automatic access to every bank
      rcs = 0;
      set_mode(MODE_AUTO_ACCESS);
      for (int b = 0; b < 4; b++) begin
         latch(9'(9'h0a5 + b), 9'(9'h15a - b), b[1:0]);
         ras_n = 0;
         tick(6);
         chk(row_n, {5'h00, ~(4'h1 << b)});
         chk(mux_addr, 9'(9'h15a - b));
         chk(col_n, 1'b0);
         ras_n = 1;
         tick(5);
         chk(row_n, 4'hf);
      end
      // external access with a transparent latch
      set_mode(MODE_EXT_ACCESS);
      strobe = 1;
      row_addr = 9'h1c3;
      col_addr = 9'h03c;
      {bs_hi, bs_lo} = 2'h2;
      rcs = 1;
      tick(5);
      chk(mux_addr, 9'h1c3);
      ras_n = 0;
      tick(4);
      chk(row_n, 4'hb);
      chk(col_n, 1'b1);
      rcs = 0;
      tick(4);
      chk(mux_addr, 9'h03c);
      cas_n = 0;
      tick(4);
      chk(col_n, 1'b0);
      cas_n = 1;
      ras_n = 1;
      rcs = 1;
      cs_n = 1;
      tick(4);
      chk(mux_oe, 1'b0);
      chk(bus_addr, 9'h1ff);
      chk(s_oe, 1'b0);
      cs_n = 0;
      // undefined mode codes keep strobes idle
      for (int m = 2; m < 8; m++) begin
         if (m == 4 || m == 5) continue;
         set_mode(m[2:0]);
         ras_n = 0;
         tick(4);
         chk(row_n, 4'hf);
         chk(col_n, 1'b1);
         chk(mux_addr, 9'h1c3);
         ras_n = 1;
         tick(4);
      end
      // hidden refresh: deselected in mode 5 with period clock high
      set_mode(MODE_AUTO_ACCESS);
      cs_n = 1;
      tick(4);
      ras_n = 0;
      tick(5);
      chk(row_n, 4'h0);
      chk(mux_addr, 9'h001);
      ras_n = 1;
      tick(4);
      cs_n = 0;
      // refresh request with the period clock low
      set_mode(MODE_AUTO_REFRESH);
      rcs = 0;
      tick(4);
      chk(pin_oe, 1'b1);
      rcs = 1;
      tick(4);
      conclude();
   end
endmodule // tb
